// [strap_cfg_pkg.sv]
// constants and types for the board strap configuration block
// assumes a 40 MHz system clock and a 32-bit apb register bus
package strap_cfg_pkg;

  // ----------------------------------------------------------------
  // operating modes, decoded from the two mode switches
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    normal_operating_mode = 2'b00, // flow loaded from flash
    legacy_compat_mode = 2'b01, // fixed flow, source switch read
    standalone_mode_a = 2'b10, // fixed flow, internal loop
    integration_test_mode = 2'b11 // timing switches ignored
  } operating_mode_sel_t;

  // ----------------------------------------------------------------
  // switch positions in the strap word (bit n is switch n+1, on = 1)
  // ----------------------------------------------------------------
  localparam int SW_PCM_MASTER = 0;
  localparam int SW_NIBBLE_MASTER = 1;
  localparam int SW_RATE_ADAPTER_PARAM = 2;
  localparam int SW_TRUNC = 3;
  localparam int SW_SRC_SEL = 4;
  localparam int SW_MODE_HI = 6;
  localparam int SW_MODE_LO = 7;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00; // captured straps and derived settings
  localparam logic [7:0] OFS_CTRL = 8'h04; // clock reference and level control
  localparam logic [7:0] OFS_ADD_CNT = 8'h08; // samples added, write clears
  localparam logic [7:0] OFS_DROP_CNT = 8'h0c; // samples dropped, write clears
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_CLK_REF = 0; // 0 analog port, 1 pcm port
  localparam int CTRL_MUTE = 1;
  localparam int CTRL_GAIN_LO = 8; // signed gain in dB, 7 bits
  localparam int CTRL_GAIN_HI = 14;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SAMPLE_NORMAL_OPERATING_MODE_NS = 125000; // 8 ksps
  localparam int T_SAMPLE_TRUNC_NS = 150000; // 6.67 ksps
  localparam int T_FRAME_NORMAL_OPERATING_MODE_MS = 20;
  localparam int T_FRAME_TRUNC_MS = 24;
  localparam int NIB_RATE_NORMAL_OPERATING_MODE_HZ = 9600;
  localparam int NIB_RATE_TRUNC_HZ = 8000;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int SAMPLE_NORMAL_OPERATING_MODE_CYC = T_SAMPLE_NORMAL_OPERATING_MODE_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_TRUNC_CYC = T_SAMPLE_TRUNC_NS / CLK_PERIOD_NS;
  localparam int FRAME_NORMAL_OPERATING_MODE_CYC = T_FRAME_NORMAL_OPERATING_MODE_MS * (1000000 / CLK_PERIOD_NS);
  localparam int FRAME_TRUNC_CYC = T_FRAME_TRUNC_MS * (1000000 / CLK_PERIOD_NS);
  localparam int NIB_HALF_NORMAL_OPERATING_MODE_CYC = CLK_HZ / (2 * NIB_RATE_NORMAL_OPERATING_MODE_HZ);
  localparam int NIB_HALF_TRUNC_CYC = CLK_HZ / (2 * NIB_RATE_TRUNC_HZ);
  localparam int SAMPLES_PER_FRAME = 160; // same in both timing modes
  localparam int GAIN_MIN_DB = -36;
  localparam int GAIN_MAX_DB = 21;

endpackage : strap_cfg_pkg

// [vocoder_board_strap_config.sv]
// power-up strap capture, derived board settings, internal timing,
// sample add/drop reporting and apb register access
// assumes straps and external timing strobes arrive asynchronously
//
// Contract
// - straps sampled once, later changes ignored
// - pcm master switch picks pcm timing source
// - nibble master switch picks nibble timing source
// - rate adapter needs switch and truncated mode
// - truncated switch picks starting timing mode
// - test mode ignores adapter and truncated switches
// - source switch read only in legacy mode
// - source switch on routes pcm, off codec
// - two mode switches decode four operating modes
// - internal sample rate 8 or 6.67 ksps
// - compressed frames every 20 or 24 ms
// - nibble clock 9600 or 8000 Hz
// - external clocking ignores internal rate parameters
// - linear task timed from selected reference port
// - adapter resamples pcm to truncated rate
// - codec rate shifts to truncated rate internally
// - external nibble timing adds or drops samples
// - error pulse per add/drop, readable counters
// - normal mode loads flash flow, others fixed
// - gain adjustable from -36 to +21 dB
`timescale 1ns/1ps
module vocoder_board_strap_config #(
  parameter int SAMPLE_NORMAL_OPERATING_MODE_CYC = strap_cfg_pkg::SAMPLE_NORMAL_OPERATING_MODE_CYC,
  parameter int SAMPLE_TRUNC_CYC = strap_cfg_pkg::SAMPLE_TRUNC_CYC,
  parameter int FRAME_NORMAL_OPERATING_MODE_CYC = strap_cfg_pkg::FRAME_NORMAL_OPERATING_MODE_CYC,
  parameter int FRAME_TRUNC_CYC = strap_cfg_pkg::FRAME_TRUNC_CYC,
  parameter int CNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_sw, // board switches, on = 1
  input wire logic i_ext_pcm_fsync, // pcm frame strobe from host
  input wire logic i_ext_nib_frame, // nibble frame strobe from host
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_cfg_valid,
  output logic [1:0] o_operating_mode,
  output logic o_pcm_timing_master,
  output logic o_nibble_timing_source_sel,
  output logic o_truncated_mode,
  output logic o_rate_adapter_en,
  output logic o_codec_trunc_rate,
  output logic o_voice_from_pcm,
  output logic o_flow_from_flash,
  output logic o_flow_fixed,
  output logic o_pcm_fsync,
  output logic o_nib_clk,
  output logic o_nib_frame,
  output logic o_lin_task_tick,
  output logic o_err_pulse,
  output logic [6:0] o_gain_db,
  output logic o_gain_mute
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamp a signed gain request into the supported range
  function automatic logic [6:0] clamp_gain(input logic [6:0] g);
    logic signed [6:0] s, lo, hi; // bounds kept signed so the compare is signed
    s = $signed(g);
    lo = 7'(strap_cfg_pkg::GAIN_MIN_DB);
    hi = 7'(strap_cfg_pkg::GAIN_MAX_DB);
    if (s < lo) clamp_gain = lo;
    else if (s > hi) clamp_gain = hi;
    else clamp_gain = g;
  endfunction : clamp_gain

  // rising edge of a synchronised strobe
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction : rise

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sw_meta_q; // first stage, read only by the second
  logic [7:0] sw_sync_q;
  logic [1:0] strb_meta_q; // pcm, nibble strobes
  logic [1:0] strb_sync_q;
  logic [1:0] strb_prev_q; // for edge detection on the settled stage

  // not reset: they must carry the pins through reset so the capture
  // after release sees settled switch levels
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      sw_meta_q <= i_sw;
      sw_sync_q <= sw_meta_q;
      strb_meta_q <= {i_ext_nib_frame, i_ext_pcm_fsync};
      strb_sync_q <= strb_meta_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      strb_prev_q <= 2'h0;
    end else if (i_ce) begin
      strb_prev_q <= strb_sync_q;
    end
  end

  logic ext_pcm_edge;
  logic ext_nib_edge;
  assign ext_pcm_edge = rise(strb_sync_q[0], strb_prev_q[0]);
  assign ext_nib_edge = rise(strb_sync_q[1], strb_prev_q[1]);

  // ----------------------------------------------------------------
  // one-shot strap capture
  // ----------------------------------------------------------------
  logic [7:0] strap_q; // held until the next power-up reset
  logic cap_done_q;

  // captured on the first enabled edge after release, never again
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cap_done_q <= 1'b0;
      strap_q <= 8'h00;
    end else if (i_ce && !cap_done_q) begin
      cap_done_q <= 1'b1;
      strap_q <= sw_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // derived settings
  // ----------------------------------------------------------------
  strap_cfg_pkg::operating_mode_sel_t mode; // operating_mode_sel
  logic is_test;
  logic is_legacy;
  logic trunc_mode;
  logic pcm_master;
  logic nibble_timing_source_sel;

  // first mode switch is the high bit of the mode code
  assign mode = strap_cfg_pkg::operating_mode_sel_t'(
    {strap_q[strap_cfg_pkg::SW_MODE_HI], strap_q[strap_cfg_pkg::SW_MODE_LO]});
  assign is_test = (mode == strap_cfg_pkg::integration_test_mode);
  assign is_legacy = (mode == strap_cfg_pkg::legacy_compat_mode);
  // test mode drops both timing switches
  assign trunc_mode = strap_q[strap_cfg_pkg::SW_TRUNC] & ~is_test;
  assign pcm_master = strap_q[strap_cfg_pkg::SW_PCM_MASTER];
  assign nibble_timing_source_sel = strap_q[strap_cfg_pkg::SW_NIBBLE_MASTER];
  // the reserved switch (bit 5) is carried in status only

  assign o_cfg_valid = cap_done_q;
  assign o_operating_mode = mode;
  assign o_pcm_timing_master = pcm_master;
  assign o_nibble_timing_source_sel = nibble_timing_source_sel;
  assign o_truncated_mode = trunc_mode;
  // the adapter itself lives in the pcm datapath; this enables it
  assign o_rate_adapter_en = strap_q[strap_cfg_pkg::SW_RATE_ADAPTER_PARAM] & trunc_mode
    & ~is_test;
  assign o_codec_trunc_rate = trunc_mode;
  // source switch only has meaning in legacy mode
  assign o_voice_from_pcm = is_legacy & strap_q[strap_cfg_pkg::SW_SRC_SEL];
  assign o_flow_from_flash = cap_done_q
    & (mode == strap_cfg_pkg::normal_operating_mode);
  assign o_flow_fixed = cap_done_q & ~o_flow_from_flash;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q; // linear_task_clock_ref, mute and gain
  logic wr_en;
  logic rd_en;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & i_penable & ~i_pwrite;

  // software writes steer the clock reference and the level stage
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= strap_cfg_pkg::CTRL_RESET;
    end else if (i_ce && wr_en && i_paddr == strap_cfg_pkg::OFS_CTRL) begin
      ctrl_q <= i_pwdata;
    end
  end

  // level stage: out-of-range requests are clamped, not wrapped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_gain_db <= 7'h00;
      o_gain_mute <= 1'b0;
    end else if (i_ce) begin
      o_gain_db <= clamp_gain(ctrl_q[strap_cfg_pkg::CTRL_GAIN_HI:
        strap_cfg_pkg::CTRL_GAIN_LO]);
      o_gain_mute <= ctrl_q[strap_cfg_pkg::CTRL_MUTE];
    end
  end

  // ----------------------------------------------------------------
  // internal timebase: sample, frame and nibble clock dividers
  // ----------------------------------------------------------------
  logic [15:0] smp_cnt_q;
  logic [19:0] frm_cnt_q;
  logic [11:0] nib_cnt_q;
  logic smp_tick;
  logic frm_tick;
  logic [15:0] smp_last;
  logic [19:0] frm_last;
  logic [11:0] nib_last;

  assign smp_last = trunc_mode ? 16'(SAMPLE_TRUNC_CYC - 1)
    : 16'(SAMPLE_NORMAL_OPERATING_MODE_CYC - 1);
  assign frm_last = trunc_mode ? 20'(FRAME_TRUNC_CYC - 1)
    : 20'(FRAME_NORMAL_OPERATING_MODE_CYC - 1);
  assign nib_last = trunc_mode ? 12'(strap_cfg_pkg::NIB_HALF_TRUNC_CYC - 1)
    : 12'(strap_cfg_pkg::NIB_HALF_NORMAL_OPERATING_MODE_CYC - 1);
  assign smp_tick = cap_done_q && (smp_cnt_q == smp_last);
  assign frm_tick = cap_done_q && (frm_cnt_q == frm_last);

  // codec sample divider always runs: it clocks the analog port
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      smp_cnt_q <= 16'h0000;
    end else if (i_ce && cap_done_q) begin
      smp_cnt_q <= smp_tick ? 16'h0000 : smp_cnt_q + 16'h0001;
    end
  end

  // frame and nibble dividers only run when this end masters nibbles
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      frm_cnt_q <= 20'h00000;
      nib_cnt_q <= 12'h000;
      o_nib_clk <= 1'b0;
    end else if (i_ce && cap_done_q && nibble_timing_source_sel) begin
      frm_cnt_q <= frm_tick ? 20'h00000 : frm_cnt_q + 20'h00001;
      if (nib_cnt_q == nib_last) begin
        nib_cnt_q <= 12'h000;
        o_nib_clk <= ~o_nib_clk;
      end else begin
        nib_cnt_q <= nib_cnt_q + 12'h001;
      end
    end
  end

  // strobes out: registered; nibble frame and pcm fsync quiet when the host owns their timing
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_nib_frame <= 1'b0;
      o_pcm_fsync <= 1'b0;
      o_lin_task_tick <= 1'b0;
    end else if (i_ce) begin
      o_nib_frame <= nibble_timing_source_sel & frm_tick;
      o_pcm_fsync <= pcm_master & smp_tick;
      // pcm reference follows whichever end times the pcm port
      if (ctrl_q[strap_cfg_pkg::CTRL_CLK_REF]) begin
        o_lin_task_tick <= pcm_master ? smp_tick : ext_pcm_edge;
      end else begin
        o_lin_task_tick <= smp_tick;
      end
    end
  end

  // ----------------------------------------------------------------
  // drift tracking against external nibble frames
  // ----------------------------------------------------------------
  logic drift_on;
  logic [8:0] frm_smp_q; // codec samples since last host frame
  logic armed_q; // a first host frame has been seen
  logic add_evt;
  logic drop_evt;

  // only meaningful when the host times nibbles and audio is analog
  assign drift_on = cap_done_q & ~nibble_timing_source_sel
    & ~ctrl_q[strap_cfg_pkg::CTRL_CLK_REF];
  assign add_evt = drift_on & armed_q & ext_nib_edge
    & (frm_smp_q < 9'(strap_cfg_pkg::SAMPLES_PER_FRAME));
  assign drop_evt = drift_on & armed_q & ext_nib_edge
    & (frm_smp_q > 9'(strap_cfg_pkg::SAMPLES_PER_FRAME));

  // counts saturate so a stopped host clock cannot wrap the count
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      frm_smp_q <= 9'h000;
      armed_q <= 1'b0;
    end else if (i_ce) begin
      if (!drift_on) begin
        frm_smp_q <= 9'h000;
        armed_q <= 1'b0;
      end else if (ext_nib_edge) begin
        frm_smp_q <= {8'h00, smp_tick};
        armed_q <= 1'b1;
      end else if (smp_tick && frm_smp_q != 9'h1ff) begin
        frm_smp_q <= frm_smp_q + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // error pulse and add/drop counters
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] add_cnt_q;
  logic [CNT_W-1:0] drop_cnt_q;
  logic clr_add;
  logic clr_drop;
  assign clr_add = wr_en && i_paddr == strap_cfg_pkg::OFS_ADD_CNT;
  assign clr_drop = wr_en && i_paddr == strap_cfg_pkg::OFS_DROP_CNT;

  // an event in the clearing cycle wins and is counted from zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      add_cnt_q <= '0;
      drop_cnt_q <= '0;
      o_err_pulse <= 1'b0;
    end else if (i_ce) begin
      o_err_pulse <= add_evt | drop_evt;
      if (add_evt) add_cnt_q <= (clr_add ? '0 : add_cnt_q) + 1'b1;
      else if (clr_add) add_cnt_q <= '0;
      if (drop_evt) drop_cnt_q <= (clr_drop ? '0 : drop_cnt_q) + 1'b1;
      else if (clr_drop) drop_cnt_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait states, unmapped offsets answer with slverr
  // ----------------------------------------------------------------
  logic mapped;
  assign mapped = (i_paddr == strap_cfg_pkg::OFS_STATUS)
    || (i_paddr == strap_cfg_pkg::OFS_CTRL)
    || (i_paddr == strap_cfg_pkg::OFS_ADD_CNT)
    || (i_paddr == strap_cfg_pkg::OFS_DROP_CNT);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  // read data is combinational from the selected register
  always_comb begin
    o_prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (i_paddr)
        strap_cfg_pkg::OFS_STATUS: o_prdata = {16'h0000, o_flow_from_flash,
          o_voice_from_pcm, nibble_timing_source_sel, pcm_master, o_rate_adapter_en,
          trunc_mode, mode, strap_q};
        strap_cfg_pkg::OFS_CTRL: o_prdata = ctrl_q;
        strap_cfg_pkg::OFS_ADD_CNT: o_prdata = 32'(add_cnt_q);
        strap_cfg_pkg::OFS_DROP_CNT: o_prdata = 32'(drop_cnt_q);
        default: o_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_captured;
    i_ce && cap_done_q;
  endsequence

  a_strap_held: assert property (s_captured |=> $stable(strap_q))
    else $error("strap word changed after capture");
  a_first_capture: assert property (i_ce && !i_sys_rst && !cap_done_q |=> cap_done_q
    && strap_q == $past(sw_sync_q))
    else $error("straps not captured on first enabled edge");
  a_test_no_trunc: assert property (is_test |-> !o_truncated_mode
    && !o_rate_adapter_en)
    else $error("timing switches honoured in test mode");
  a_adapter_gate: assert property (o_rate_adapter_en |-> o_truncated_mode
    && strap_q[strap_cfg_pkg::SW_RATE_ADAPTER_PARAM])
    else $error("adapter on outside truncated mode");
  a_source_legacy: assert property (o_voice_from_pcm |-> mode
    == strap_cfg_pkg::legacy_compat_mode)
    else $error("source switch used outside legacy mode");
  a_flow_select: assert property (cap_done_q |-> o_flow_from_flash
    == (strap_q[7:6] == 2'b00) && o_flow_fixed != o_flow_from_flash)
    else $error("flow source does not match mode");
  a_error_pulse: assert property (i_ce && (add_evt || drop_evt) |=> o_err_pulse)
    else $error("add or drop without error pulse");
  a_add_count: assert property (i_ce && add_evt && !clr_add
    && add_cnt_q != '1 |=> add_cnt_q == $past(add_cnt_q) + 1'b1)
    else $error("add counter missed an event");
  a_gain_range: assert property (
    $signed(o_gain_db) >= $signed(7'(strap_cfg_pkg::GAIN_MIN_DB))
    && $signed(o_gain_db) <= $signed(7'(strap_cfg_pkg::GAIN_MAX_DB)))
    else $error("gain outside range");
  a_nib_quiet: assert property (!nibble_timing_source_sel |-> !o_nib_frame && !o_nib_clk)
    else $error("nibble timing driven while external");
  a_sample_period: assert property (i_ce && smp_tick ##1 i_ce [*2]
    |-> !smp_tick)
    else $error("sample ticks too close");

endmodule : vocoder_board_strap_config

// [host_timing_model.sv]
// host side of the voice ports: frame strobes for the nibble and pcm links
// assumes the bench sets i_period and raises i_run on a rising clock edge
`timescale 1ns/1ps
module host_timing_model (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic [31:0] i_period,
  output logic o_pcm_fsync,
  output logic o_nib_frame
);
  // ------------------------------------------------------------------
  // frame counter
  // ------------------------------------------------------------------
  int cnt_q; // position inside the host frame

  // restart at zero on every run so the first strobe comes at once
  always_ff @(posedge i_clk) begin
    if (!i_run) begin
      cnt_q <= 0;
    end else if (cnt_q == i_period - 1) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end

  // strobes are driven low while idle, never left floating
  assign o_nib_frame = i_run && (cnt_q < 4);
  assign o_pcm_fsync = i_run && ((cnt_q % 20) < 2);
endmodule : host_timing_model

// [testbench.sv]
// self-checking bench for the strap configuration block
// assumes the host model above and apb with a zero-wait slave
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic i_clk, i_sys_rst, i_psel, i_penable, i_pwrite, run;
  logic [7:0] i_sw, i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic o_pready, o_pslverr, o_cfg_valid, o_pcm_timing_master, o_nibble_timing_source_sel;
  logic o_truncated_mode, o_rate_adapter_en, o_codec_trunc_rate, o_voice_from_pcm, e;
  logic o_flow_from_flash, o_flow_fixed, o_pcm_fsync, o_nib_clk, o_nib_frame;
  logic o_lin_task_tick, o_err_pulse, o_gain_mute, h_pcm, h_nib, tr, ce;
  logic [1:0] o_operating_mode, mm;
  logic [6:0] o_gain_db;
  logic [7:0] sw;
  int per, n, n_err, n_mismatch, n_checks, cyc;

  vocoder_board_strap_config #(.SAMPLE_NORMAL_OPERATING_MODE_CYC(20), .SAMPLE_TRUNC_CYC(24),
    .FRAME_NORMAL_OPERATING_MODE_CYC(3200), .FRAME_TRUNC_CYC(3840)) i_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_sw(i_sw),
    .i_ext_pcm_fsync(h_pcm), .i_ext_nib_frame(h_nib), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_cfg_valid(o_cfg_valid), .o_operating_mode(o_operating_mode),
    .o_pcm_timing_master(o_pcm_timing_master),
    .o_nibble_timing_source_sel(o_nibble_timing_source_sel),
    .o_truncated_mode(o_truncated_mode), .o_rate_adapter_en(o_rate_adapter_en),
    .o_codec_trunc_rate(o_codec_trunc_rate), .o_voice_from_pcm(o_voice_from_pcm),
    .o_flow_from_flash(o_flow_from_flash), .o_flow_fixed(o_flow_fixed),
    .o_pcm_fsync(o_pcm_fsync), .o_nib_clk(o_nib_clk), .o_nib_frame(o_nib_frame),
    .o_lin_task_tick(o_lin_task_tick), .o_err_pulse(o_err_pulse),
    .o_gain_db(o_gain_db), .o_gain_mute(o_gain_mute));

  host_timing_model i_host (.i_clk(i_clk), .i_run(run), .i_period(per),
    .o_pcm_fsync(h_pcm), .o_nib_frame(h_nib));

  // ------------------------------------------------------------------
  // clock, hang guard and error strobe monitor
  // ------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // the whole run needs about 47k cycles; past 90k something hangs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      conclude();
    end
  end

  // sampled on the falling edge so the pulse is settled
  always @(negedge i_clk) begin
    if (o_err_pulse === 1'b1) begin
      n_err++;
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task conclude();
    $display("mismatches=%0d checks=%0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // switches held through reset; the reserved switch stays off
  task automatic rst(input logic [7:0] s);
    @(posedge i_clk);
    i_sw <= s;
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask : rst

  function automatic logic pick(input int s);
    case (s)
      0: return o_pcm_fsync;
      1: return o_nib_frame;
      2: return o_nib_clk;
      default: return o_lin_task_tick;
    endcase
  endfunction : pick

  // rise to next rise for pulses, rise to fall for levels
  task automatic gap(input int s, input bit lvl);
    int k;
    k = 0;
    while (pick(s) !== 1'b0 && k < 9000) begin @(negedge i_clk); k++; end
    while (pick(s) !== 1'b1 && k < 9000) begin @(negedge i_clk); k++; end
    n = 0;
    do begin @(negedge i_clk); n++; end while (pick(s) === 1'b1 && n < 9000);
    while (!lvl && pick(s) !== 1'b1 && n < 9000) begin @(negedge i_clk); n++; end
  endtask : gap

  task automatic timing(input logic [7:0] s, input int smp, input int frm, input int half);
    rst(s);
    gap(0, 0);
    chk(n, smp);
    gap(3, 0);
    chk(n, smp);
    gap(1, 0);
    chk(n, frm);
    gap(2, 1);
    chk(n, half);
  endtask : timing

  // host frames of p cycles against 20-cycle codec ticks
  task automatic drift(input int p, input int adds, input int drops);
    rst(8'h00);
    n_err = 0;
    @(posedge i_clk);
    per <= p;
    run <= 1'b1;
    repeat (3 * p + 40) @(posedge i_clk);
    run <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk(n_err, adds + drops);
    apb(0, strap_cfg_pkg::OFS_ADD_CNT, 32'h0);
    chk(q, adds);
    apb(0, strap_cfg_pkg::OFS_DROP_CNT, 32'h0);
    chk(q, drops);
    apb(1, strap_cfg_pkg::OFS_DROP_CNT, 32'h0);
    apb(0, strap_cfg_pkg::OFS_DROP_CNT, 32'h0);
    chk(q, 0);
  endtask : drift

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {i_sys_rst, i_psel, i_penable, i_pwrite, run, ce} = 6'h21;
    {i_sw, i_paddr, i_pwdata, per} = '0;
    for (int b = 0; b < 2; b++) begin
      for (int m = 0; m < 4; m++) begin
        mm = m[1:0];
        sw = (b == 0) ? 8'h1f : 8'h0a;
        sw[6] = mm[1];
        sw[7] = mm[0];
        rst(sw);
        tr = sw[3] & (mm != 2'h3);
        chk({o_cfg_valid, o_operating_mode}, {1'b1, mm});
        chk({o_pcm_timing_master, o_nibble_timing_source_sel}, {sw[0], sw[1]});
        chk({o_truncated_mode, o_codec_trunc_rate}, {tr, tr});
        chk(o_rate_adapter_en, sw[2] & tr);
        chk(o_voice_from_pcm, (mm == 2'h1) & sw[4]);
        chk({o_flow_from_flash, o_flow_fixed}, {mm == 2'h0, mm != 2'h0});
        apb(0, strap_cfg_pkg::OFS_STATUS, 32'h0);
        chk(q[15:0], {mm == 2'h0, (mm == 2'h1) & sw[4], sw[1], sw[0],
          sw[2] & tr, tr, mm, sw});
        i_sw <= ~sw;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        chk({o_operating_mode, o_truncated_mode}, {mm, tr});
      end
    end
    timing(8'h03, 20, 3200, strap_cfg_pkg::NIB_HALF_NORMAL_OPERATING_MODE_CYC);
    timing(8'h0b, 24, 3840, strap_cfg_pkg::NIB_HALF_TRUNC_CYC);
    drift(3180, 3, 0);
    drift(3220, 0, 3);
    // gain clamps at both ends, in-range value reads back as written
    apb(1, strap_cfg_pkg::OFS_CTRL, 32'h0000_3f02);
    repeat (2) @(posedge i_clk);
    chk({o_gain_mute, o_gain_db}, {1'b1, 7'h15});
    apb(1, strap_cfg_pkg::OFS_CTRL, 32'h0000_4000);
    repeat (2) @(posedge i_clk);
    chk({o_gain_mute, o_gain_db}, {1'b0, 7'h5c});
    apb(1, strap_cfg_pkg::OFS_CTRL, 32'h0000_7b03);
    repeat (2) @(posedge i_clk);
    chk({o_gain_mute, o_gain_db}, {1'b1, 7'h7b});
    // pcm reference with host pcm timing: silent host means no task ticks
    n = 0;
    repeat (60) begin
      @(negedge i_clk);
      n += o_lin_task_tick;
    end
    chk(n, 0);
    @(posedge i_clk);
    per <= 3180;
    run <= 1'b1;
    gap(3, 0);
    chk(n, 20);
    @(posedge i_clk);
    run <= 1'b0;
    apb(0, strap_cfg_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h0000_7b03);
    // clock enable low: a write must not land
    ce <= 1'b0;
    apb(1, strap_cfg_pkg::OFS_CTRL, 32'h0);
    ce <= 1'b1;
    apb(0, strap_cfg_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h0000_7b03);
    // unmapped place: error response and zero data
    apb(1, 8'h10, 32'hffff_ffff);
    chk(e, 1'b1);
    apb(0, 8'h10, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    conclude();
  end
endmodule : testbench
